/* hw/core_tuning_defines.vh */
// bit positions, reset values and timing counts of the core tuning register
`ifndef CORE_TUNING_DEFINES_VH
`define CORE_TUNING_DEFINES_VH
`define CTC_ADDR_CONFIG 12'h000
`define CTC_ADDR_STATUS 12'h004
`define CTC_BIT_WAIT_EXIT 31
`define CTC_BIT_FAST_PREF 30
`define CTC_BIT_IMPL_HB 29
`define CTC_BIT_FPR1 28
`define CTC_BIT_STRICT_HB 27
`define CTC_BIT_CP2_IO 26
`define CTC_BIT_LDST_IO 25
`define CTC_BIT_ARITH_IO 24
`define CTC_BIT_BIMODAL 23
`define CTC_BIT_SINGLE_GRAD 22
`define CTC_BIT_STRICT_UNC 21
`define CTC_BIT_CACHE_INIT 18
`define CTC_BIT_FPR0 17
`define CTC_BIT_ALIAS_FREE 16
`define CTC_BIT_PREF_HI 12
`define CTC_BIT_PREF_LO 11
`define CTC_BIT_CP1_IO 6
`define CTC_PREF_RESET 2'h1
`define CTC_WR_MASK 32'h6FE01840
`define CTC_HB_BUBBLE_CYC 4'hB
`define CTC_UNC_BUBBLE_CYC 4'hF
`define CTC_FPR_FULL 2'h0
`define CTC_FPR_HALF 2'h1
`define CTC_FPR_TWO_THIRDS 2'h2
`endif

/* hw/issue_stall_timer.v */
// down-counter that holds an issue stall for a fixed number of cycles
`timescale 1ns/10ps
`include "core_tuning_defines.vh"
module issue_stall_timer #(
  parameter WIDTH = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_start,
  input wire [WIDTH-1:0] i_cycles,
  output wire o_busy
);
  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  always @* begin
    count_d = count_q;
    if (i_start && count_q == {WIDTH{1'b0}}) begin
      count_d = i_cycles;
    end else if (count_q != {WIDTH{1'b0}}) begin
      count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  assign o_busy = (count_q != {WIDTH{1'b0}});
endmodule

/* hw/core_tuning_config.v */
// core tuning configuration register with apb access and pipeline policy outputs
//
// Notes on behaviour
// - wait-exit flag is read-only; 1: masked-eligible interrupt ends wait
// - fast-prefetch clear: hint 31 behaves like hint 30
// - implicit barrier set: interlock system-register producers before reads, di/ei, eret
// - implicit barrier makes kernel register jumps barriers; clear after reset
// - default barrier stalls only if system-register write in flight, 11 clocks, then until the pipe drains
// - coprocessor data in pipeline order unless matching in-order bit set
// - each coprocessor data item carries an age tag
// - separate bits force arithmetic or load/store issue in program order
// - predictor gshare by default, bimodal when select bit set
// - single graduation bit limits retirement to one per cycle
// - strict uncached: in order, 15-cycle bubble between instructions
// - branch delay slot fetched without the uncached bubble
// - cache-init-not-needed field reads zero always
// - fpu clock ratio read-only: 0 full, 1 half, 2 two-thirds
// - alias-free field read-only, set when data cache avoids aliases
// - prefetch field resets 01; 00 none, 01 next line
// - non read-only control fields are read/write
// - prefetch 11 fetches two next lines; 10 reserved
// - other writable control fields reset to zero
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "core_tuning_defines.vh"
module core_tuning_config #(
  parameter WAIT_EXIT_ON_MASKED_IRQ = 1'b1,
  parameter [1:0] FPU_CLOCK_RATIO = 2'h0,
  parameter DCACHE_ALIAS_FREE = 1'b1,
  parameter AGE_WIDTH = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // wait and prefetch hints
  input wire i_wait_active,
  input wire i_irq_pending,
  input wire i_global_irq_enable,
  output reg o_wait_exit,
  input wire [4:0] i_pref_hint,
  output reg [4:0] o_pref_hint_eff,
  // hazard handling
  input wire i_issue_valid,
  input wire i_issue_is_barrier,
  input wire i_issue_is_sysreg_consumer,
  input wire i_issue_is_reg_jump,
  input wire i_kernel_mode,
  input wire i_sysreg_write_in_flight,
  input wire i_pipe_empty,
  output wire o_issue_stall,
  // coprocessor data
  input wire i_cp_data_valid,
  input wire i_cp_data_sel,
  input wire [AGE_WIDTH-1:0] i_cp_data_age,
  output reg [AGE_WIDTH-1:0] o_cp_data_age,
  output reg o_cp_data_program_order,
  // policy outputs
  output reg o_arith_issue_in_order,
  output reg o_ldst_issue_in_order,
  output reg o_bimodal_predictor_select,
  output reg [1:0] o_max_graduate,
  // uncached fetch
  input wire i_fetch_valid,
  input wire i_fetch_uncached,
  input wire i_fetch_delay_slot,
  output wire o_fetch_stall,
  // instruction cache prefetch
  input wire i_icache_miss,
  output reg [1:0] o_icache_prefetch_lines
);
  localparam [1:0] HB_IDLE = 2'b00;
  localparam [1:0] HB_BUBBLE = 2'b01;
  localparam [1:0] HB_DRAIN = 2'b10;
  localparam NUM_TIMERS = 2;
  localparam TIMER_WIDTH = 4;

  reg [31:0] cfg_q;
  reg [31:0] live_q;
  reg [31:0] rd_word;
  reg hb_start;
  reg [1:0] hb_state_q;
  reg [1:0] hb_state_d;
  wire hb_busy;
  wire unc_busy;
  wire unc_start;
  wire apb_write;
  wire apb_read_cycle;
  wire [NUM_TIMERS-1:0] timer_start;
  wire [NUM_TIMERS*TIMER_WIDTH-1:0] timer_cycles;
  wire [NUM_TIMERS-1:0] timer_busy;
  genvar t;

  function addr_is_cfg;
    input [11:0] addr;
    begin
      addr_is_cfg = (addr == `CTC_ADDR_CONFIG);
    end
  endfunction

  // read-only and zero positions are fixed at read time, never stored
  function [31:0] ro_fields;
    input dummy;
    begin
      ro_fields = 32'h0;
      ro_fields[`CTC_BIT_WAIT_EXIT] = WAIT_EXIT_ON_MASKED_IRQ;
      ro_fields[`CTC_BIT_CACHE_INIT] = 1'b0;
      ro_fields[`CTC_BIT_FPR1] = FPU_CLOCK_RATIO[1];
      ro_fields[`CTC_BIT_FPR0] = FPU_CLOCK_RATIO[0];
      ro_fields[`CTC_BIT_ALIAS_FREE] = DCACHE_ALIAS_FREE;
    end
  endfunction

  assign apb_write = i_psel && i_penable && i_pwrite;
  assign apb_read_cycle = i_psel && !i_pwrite;
  // zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_is_cfg(i_paddr);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      // only the prefetch field leaves reset non-zero
      cfg_q <= 32'h0;
      cfg_q[`CTC_BIT_PREF_HI:`CTC_BIT_PREF_LO] <= `CTC_PREF_RESET;
    end else if (apb_write && addr_is_cfg(i_paddr)) begin
      cfg_q <= i_pwdata & `CTC_WR_MASK;
    end
  end

  // policies used by issue logic track cfg one cycle later, once the write retired
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      live_q <= 32'h0;
      live_q[`CTC_BIT_PREF_HI:`CTC_BIT_PREF_LO] <= `CTC_PREF_RESET;
    end else begin
      live_q <= cfg_q;
    end
  end

  // unmapped offsets read as zero and raise the error flag instead
  always @* begin
    rd_word = 32'h0;
    if (addr_is_cfg(i_paddr)) begin
      rd_word = cfg_q | ro_fields(1'b0);
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (apb_read_cycle && !i_penable) begin
      o_prdata <= rd_word;
    end
  end

  // wait release
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wait_exit <= 1'b0;
    end else begin
      o_wait_exit <= i_wait_active && i_irq_pending &&
        (i_global_irq_enable || WAIT_EXIT_ON_MASKED_IRQ);
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pref_hint_eff <= 5'h0;
    end else if (i_pref_hint == 5'h1F && !live_q[`CTC_BIT_FAST_PREF]) begin
      o_pref_hint_eff <= 5'h1E;
    end else begin
      o_pref_hint_eff <= i_pref_hint;
    end
  end

  // barrier decision: an issued barrier-class instruction arms the bubble in strict mode or while a system-register write is in flight
  always @* begin
    hb_start = 1'b0;
    if (i_issue_valid) begin
      if (i_issue_is_barrier) begin
        hb_start = live_q[`CTC_BIT_STRICT_HB] || i_sysreg_write_in_flight;
      end else if (live_q[`CTC_BIT_IMPL_HB] && i_sysreg_write_in_flight &&
                   i_issue_is_sysreg_consumer) begin
        hb_start = 1'b1;
      end else if (live_q[`CTC_BIT_IMPL_HB] && i_kernel_mode &&
                   i_issue_is_reg_jump) begin
        hb_start = 1'b1;
      end
    end
  end

  // a barrier holds issue for the fixed bubble, then until the pipe has drained
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      hb_state_q <= HB_IDLE;
    end else begin
      hb_state_q <= hb_state_d;
    end
  end

  always @* begin
    hb_state_d = hb_state_q;
    case (hb_state_q)
      HB_IDLE: begin
        if (hb_start) begin
          hb_state_d = HB_BUBBLE;
        end
      end
      HB_BUBBLE: begin
        if (!hb_busy && !hb_start) begin
          hb_state_d = i_pipe_empty ? HB_IDLE : HB_DRAIN;
        end
      end
      HB_DRAIN: begin
        if (hb_start) begin
          hb_state_d = HB_BUBBLE;
        end else if (i_pipe_empty) begin
          hb_state_d = HB_IDLE;
        end
      end
      default: begin
        hb_state_d = HB_IDLE;
      end
    endcase
  end

  // slot 0 is the barrier bubble, slot 1 the strict uncached bubble
  assign unc_start = i_fetch_valid && i_fetch_uncached && !i_fetch_delay_slot &&
                     live_q[`CTC_BIT_STRICT_UNC];
  assign timer_start = {unc_start, hb_start};
  assign timer_cycles = {`CTC_UNC_BUBBLE_CYC, `CTC_HB_BUBBLE_CYC};

  generate
    for (t = 0; t < NUM_TIMERS; t = t + 1) begin : g_stall
      issue_stall_timer #(
        .WIDTH(TIMER_WIDTH)
      ) issue_stall_timer_inst (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_start(timer_start[t]),
        .i_cycles(timer_cycles[t*TIMER_WIDTH +: TIMER_WIDTH]),
        .o_busy(timer_busy[t])
      );
    end
  endgenerate

  assign hb_busy = timer_busy[0];
  assign unc_busy = timer_busy[1];

  // stall stays on through the bubble and any later drain wait
  assign o_issue_stall = hb_busy || (hb_state_q != HB_IDLE && !i_pipe_empty);

  assign o_fetch_stall = unc_busy && !i_fetch_delay_slot;

  // coprocessor data: age tag always forwarded
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cp_data_age <= {AGE_WIDTH{1'b0}};
      o_cp_data_program_order <= 1'b0;
    end else if (i_cp_data_valid) begin
      o_cp_data_age <= i_cp_data_age;
      o_cp_data_program_order <= i_cp_data_sel ? live_q[`CTC_BIT_CP2_IO] :
        live_q[`CTC_BIT_CP1_IO];
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_arith_issue_in_order <= 1'b0;
      o_ldst_issue_in_order <= 1'b0;
      o_bimodal_predictor_select <= 1'b0;
      o_max_graduate <= 2'h2;
    end else begin
      o_arith_issue_in_order <= live_q[`CTC_BIT_ARITH_IO];
      o_ldst_issue_in_order <= live_q[`CTC_BIT_LDST_IO];
      o_bimodal_predictor_select <= live_q[`CTC_BIT_BIMODAL];
      o_max_graduate <= live_q[`CTC_BIT_SINGLE_GRAD] ? 2'h1 : 2'h2;
    end
  end

  // reserved code 10 is treated as no extra prefetch
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_icache_prefetch_lines <= 2'h0;
    end else if (i_icache_miss) begin
      case (live_q[`CTC_BIT_PREF_HI:`CTC_BIT_PREF_LO])
        2'h0: o_icache_prefetch_lines <= 2'h0;
        2'h1: o_icache_prefetch_lines <= 2'h1;
        2'h3: o_icache_prefetch_lines <= 2'h2;
        default: o_icache_prefetch_lines <= 2'h0;
      endcase
    end else begin
      o_icache_prefetch_lines <= 2'h0;
    end
  end
endmodule

/* dv/core_tuning_props_properties.sv */
// port assertions for the core tuning register
`timescale 1ns/10ps
module core_tuning_props #(
  parameter AGE_WIDTH = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_wait_active,
  input wire i_irq_pending,
  input wire i_global_irq_enable,
  input wire o_wait_exit,
  input wire [4:0] i_pref_hint,
  input wire [4:0] o_pref_hint_eff,
  input wire i_cp_data_valid,
  input wire [AGE_WIDTH-1:0] i_cp_data_age,
  input wire [AGE_WIDTH-1:0] o_cp_data_age,
  input wire [1:0] o_max_graduate,
  input wire i_fetch_delay_slot,
  input wire o_fetch_stall,
  input wire o_issue_stall,
  input wire i_pipe_empty,
  input wire i_icache_miss,
  input wire [1:0] o_icache_prefetch_lines
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_wx; i_wait_active && i_irq_pending && i_global_irq_enable |=> o_wait_exit; endproperty
  a_wx: assert property (p_wx) else $error("no wait exit");
  property p_wn; !i_wait_active |=> !o_wait_exit; endproperty
  a_wn: assert property (p_wn) else $error("stray wait exit");
  property p_hint; i_pref_hint != 5'h1F |=> o_pref_hint_eff == $past(i_pref_hint); endproperty
  a_hint: assert property (p_hint) else $error("hint altered");
  property p_age; i_cp_data_valid |=> o_cp_data_age == $past(i_cp_data_age); endproperty
  a_age: assert property (p_age) else $error("age lost");
  property p_grad; o_max_graduate inside {2'h1, 2'h2}; endproperty
  a_grad: assert property (p_grad) else $error("bad graduate");
  property p_ds; i_fetch_delay_slot |-> !o_fetch_stall; endproperty
  a_ds: assert property (p_ds) else $error("delay slot stalled");
  property p_idle; !i_icache_miss |=> o_icache_prefetch_lines == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("prefetch w/o miss");
  property p_rsv; o_icache_prefetch_lines != 2'h3; endproperty
  a_rsv: assert property (p_rsv) else $error("bad line count");
  property p_drn; o_issue_stall && !i_pipe_empty |=> o_issue_stall || i_pipe_empty; endproperty
  a_drn: assert property (p_drn) else $error("stall left before drain");
  c_hb: cover property (o_issue_stall);
  c_drn: cover property (o_issue_stall && !i_pipe_empty);
  c_unc: cover property (o_fetch_stall);
  c_two: cover property (o_icache_prefetch_lines == 2'h2);
endmodule
bind core_tuning_config core_tuning_props #(.AGE_WIDTH(AGE_WIDTH)) core_tuning_props_inst (.*);

/* dv/tb_top.sv */
// self-checking bench for the core tuning register
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, rd, o_prdata;
  logic i_wait_active = 0, i_irq_pending = 0, i_global_irq_enable = 0, i_issue_valid = 0;
  logic i_issue_is_barrier = 1, i_issue_is_sysreg_consumer = 0, i_issue_is_reg_jump = 0;
  logic i_kernel_mode = 1, i_sysreg_write_in_flight = 0, i_pipe_empty = 1, i_cp_data_valid = 0;
  logic i_cp_data_sel = 0, i_fetch_valid = 0, i_fetch_uncached = 1, i_fetch_delay_slot = 0;
  logic i_icache_miss = 0, o_pready, o_pslverr, o_wait_exit, o_issue_stall, o_fetch_stall;
  logic o_cp_data_program_order, o_arith_issue_in_order, o_ldst_issue_in_order;
  logic o_bimodal_predictor_select;
  logic [4:0] i_pref_hint = 0, o_pref_hint_eff;
  logic [3:0] i_cp_data_age = 0, o_cp_data_age;
  logic [1:0] o_max_graduate, o_icache_prefetch_lines;
  int fail_count = 0, check_count = 0;
  core_tuning_config core_tuning_config_inst (.*);
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  task cmp(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1 && ++n < 20);
    if (n == 20) begin
      fail_count++;
      results;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    // policy outputs trail a write by two edges
    repeat (3) @(posedge i_sys_clk);
  endtask
  task stall(input logic u, input logic [31:0] e);
    logic [31:0] n;
    n = 0;
    @(posedge i_sys_clk);
    i_fetch_valid <= u;
    i_issue_valid <= !u;
    @(posedge i_sys_clk);
    i_fetch_valid <= 0;
    i_issue_valid <= 0;
    i_sysreg_write_in_flight <= 0;
    repeat (30) begin
      #1 n += u ? o_fetch_stall : o_issue_stall;
      @(posedge i_sys_clk);
    end
    cmp(n, e);
  endtask
  task t_regs;
    apb(0, 0, 0);
    cmp(rd, 32'h80010800);
    cmp(err, 0);
    apb(1, 0, 32'hFFFFFFFF);
    apb(0, 0, 0);
    cmp(rd, 32'hEFE11840);
    apb(0, 12'h004, 0);
    cmp(err, 1);
    // mid-run reset must bring every writable field back to its default
    i_rst <= 1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 0;
    apb(1, 12'h004, 32'hFFFFFFFF);
    cmp(err, 1);
    apb(0, 0, 0);
    cmp(rd, 32'h80010800);
  endtask
  task t_pref;
    for (int k = 0; k < 4; k++) begin
      apb(1, 0, k << 11);
      i_icache_miss <= 1;
      @(posedge i_sys_clk);
      i_icache_miss <= 0;
      #1 cmp(o_icache_prefetch_lines, k == 3 ? 2 : k & 1);
    end
    @(posedge i_sys_clk);
    i_pref_hint <= 31;
    repeat (2) @(posedge i_sys_clk);
    #1 cmp(o_pref_hint_eff, 30);
    apb(1, 0, 32'h40000000);
    cmp(o_pref_hint_eff, 31);
  endtask
  task t_stall;
    apb(1, 0, 0);
    stall(0, 0);
    i_sysreg_write_in_flight <= 1;
    stall(0, 11);
    apb(1, 0, 32'h08000000);
    stall(0, 11);
    apb(1, 0, 32'h20000000);
    i_issue_is_barrier <= 0;
    i_issue_is_reg_jump <= 1;
    stall(0, 11);
    i_kernel_mode <= 0;
    stall(0, 0);
    i_kernel_mode <= 1;
    i_issue_is_reg_jump <= 0;
    i_issue_is_sysreg_consumer <= 1;
    i_sysreg_write_in_flight <= 1;
    stall(0, 11);
    i_issue_is_sysreg_consumer <= 0;
    i_issue_is_barrier <= 1;
    apb(1, 0, 0);
    i_sysreg_write_in_flight <= 1;
    i_pipe_empty <= 0;
    stall(0, 30);
    i_pipe_empty <= 1;
    apb(1, 0, 32'h00200000);
    stall(1, 15);
    i_fetch_delay_slot <= 1;
    stall(1, 0);
    i_fetch_delay_slot <= 0;
    apb(1, 0, 0);
    stall(1, 0);
  endtask
  task t_pol;
    apb(1, 0, 32'h03C00040);
    cmp({o_arith_issue_in_order, o_ldst_issue_in_order, o_bimodal_predictor_select,
         o_max_graduate}, 5'h1D);
    i_cp_data_valid <= 1;
    i_cp_data_age <= 4'h9;
    i_wait_active <= 1;
    i_irq_pending <= 1;
    @(posedge i_sys_clk);
    i_cp_data_valid <= 0;
    #1 cmp({o_cp_data_program_order, o_cp_data_age}, 5'h19);
    cmp(o_wait_exit, 1);
    @(posedge i_sys_clk);
    i_cp_data_valid <= 1;
    i_cp_data_sel <= 1;
    i_cp_data_age <= 4'h6;
    @(posedge i_sys_clk);
    i_cp_data_valid <= 0;
    #1 cmp({o_cp_data_program_order, o_cp_data_age}, 5'h06);
    apb(1, 0, 32'h04000000);
    i_cp_data_valid <= 1;
    @(posedge i_sys_clk);
    i_cp_data_valid <= 0;
    #1 cmp({o_cp_data_program_order, o_cp_data_age}, 5'h16);
    apb(1, 0, 0);
    cmp({o_arith_issue_in_order, o_max_graduate}, 3'h2);
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 0;
    t_regs;
    t_pref;
    t_stall;
    t_pol;
    results;
  end
endmodule
